// file: rtl/ulms_pkg.sv
package ulms_pkg;

  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 16;
  localparam int ENTRY_W = 11;
  localparam int PTR_W   = 4;
  localparam int CNT_W   = 5;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] RBR_ADDR   = 32'h5000_1100;
  localparam logic [ADDR_W-1:0] LCR_ADDR   = 32'h5000_110C;
  localparam logic [ADDR_W-1:0] MCR_ADDR   = 32'h5000_1110;
  localparam logic [ADDR_W-1:0] LSR_ADDR   = 32'h5000_1114;
  localparam logic [ADDR_W-1:0] MSR_ADDR   = 32'h5000_1118;
  localparam logic [ADDR_W-1:0] RXCTL_ADDR = 32'h5000_1128;
  localparam logic [ADDR_W-1:0] DIV_ADDR   = 32'h5000_112C;
  localparam logic [ADDR_W-1:0] ISTAT_ADDR = 32'h5000_1130;
  localparam logic [ADDR_W-1:0] IMASK_ADDR = 32'h5000_1134;

  // line_status_reg fields
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_PE = 2;
  localparam int LSR_FE = 3;
  localparam int LSR_BI = 4;

  // modem_status_reg fields
  localparam int MSR_TERI = 2;
  localparam int MSR_DDCD = 3;
  localparam int MSR_CTS  = 4;
  localparam int MSR_RI   = 6;
  localparam int MSR_DCD  = 7;

  // modem_control_reg fields
  localparam int MCR_RTS  = 1;
  localparam int MCR_AUX_OUTPUT_ONE = 2;
  localparam int MCR_AUX_OUTPUT_TWO = 3;
  localparam int MCR_LOOP = 4;

  // line_control_reg and receive control fields
  localparam int LCR_PEN    = 3;
  localparam int LCR_EPS    = 4;
  localparam int RXCTL_FIFO = 0;

  // Interrupt status and mask fields
  localparam int INT_RXCHAR = 0;
  localparam int INT_LINE   = 1;
  localparam int INT_MODEM  = 2;

  // Receive entry layout: data in [7:0]
  localparam int ENT_PE = 8;
  localparam int ENT_FE = 9;
  localparam int ENT_BI = 10;

  localparam logic [15:0]      DIV_RESET   = 16'h0001;
  localparam logic [7:0]       REG8_RESET  = 8'h00;
  localparam logic [2:0]       INT_RESET   = 3'h0;
  localparam logic [3:0]       SAMPLE_MID  = 4'h7;
  localparam logic [3:0]       SAMPLE_LAST = 4'hF;
  localparam logic [2:0]       LAST_BIT    = 3'h7;
  localparam logic [7:0]       TICKS_PAR   = 8'hB0;
  localparam logic [7:0]       TICKS_NOPAR = 8'hA0;
  localparam logic [7:0]       LOW_MAX     = 8'hFF;
  localparam logic [CNT_W-1:0] FIFO_DEPTH  = 5'h10;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP,
    RX_CHECK,
    RX_WAIT_HIGH
  } ulms_rx_state_type;

endpackage

// file: rtl/ulms_status.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
// What this block does
// RQ1: Missing valid stop bit sets framing_error_flag, line_status_reg bit 3.
// RQ2: In FIFO mode parity, framing and break errors show only when their character reaches the head.
// RQ3: After framing error with nonzero data, the low stop level is taken as next start bit.
// RQ4: A break also sets framing_error_flag beside break_indication bit 4.
// RQ5: A break also sets parity_error_flag, bit 2.
// RQ6: Parity errors counted only while parity_enable_bit (line_control_reg[3]) is set.
// RQ7: Reading line_status_reg clears framing, parity and overrun flags.
// RQ8: Non-FIFO: unread character overwritten by new one sets overrun, bit 1.
// RQ9: FIFO mode: character arriving into a full FIFO is dropped, overrun set.
// RQ10: rx_data_ready bit 0 set while any received character is held.
// RQ11: modem_status_reg bit 7 is inverse carrier detect, or aux_output_two in loopback.
// RQ12: Bit 6 is inverse ring indicator, or aux_output_one in loopback.
// RQ13: Bit 4 is inverse clear-to-send, or the RTS control bit in loopback.
// RQ14: carrier_change_flag bit 3 sets on carrier change, clears on status read.
// RQ15: Carrier asserted across a reset sets carrier_change_flag after release.
// RQ16: ring_trailing_edge_flag bit 2 sets when ring goes active to inactive.
// RQ17: In loopback that flag sets when aux_output_one falls high to low.
// RQ18: Break is serial input low longer than a full character time.
// RQ19: Reserved status bits read zero and ignore writes.
module ulms_status (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [ulms_pkg::ADDR_W-1:0] addr,
  input  wire logic [ulms_pkg::DATA_W-1:0] wrData,
  input  wire logic                        wrEn,
  input  wire logic                        rdEn,
  output      logic [ulms_pkg::DATA_W-1:0] rdData,
  input  wire logic                        rxIn,
  input  wire logic                        dcdInN,
  input  wire logic                        ringIndicatorInN,
  input  wire logic                        ctsInN,
  output      logic                        irq,
  output      logic                        rtsOutN
);

  logic [7:0]                   lineControlReg;
  logic [7:0]                   modemControlReg;
  logic                         fifoMode;
  logic [15:0]                  baudDiv;
  logic [2:0]                   intMask;
  logic [2:0]                   intStat;
  logic [15:0]                  tickCnt;
  logic                         tick;
  ulms_pkg::ulms_rx_state_type  rxState;
  logic [3:0]                   sampleCnt;
  logic [2:0]                   bitCnt;
  logic [7:0]                   shiftData;
  logic                         parityBad;
  logic [7:0]                   lowCnt;
  logic                         push;
  logic [ulms_pkg::ENTRY_W-1:0] pushEntry;
  logic [ulms_pkg::ENTRY_W-1:0] rxMem [ulms_pkg::FIFO_DEPTH];
  logic [ulms_pkg::PTR_W-1:0]   wrPtr;
  logic [ulms_pkg::PTR_W-1:0]   rdPtr;
  logic [ulms_pkg::CNT_W-1:0]   rxCount;
  logic                         headShown;
  logic                         framingErrorFlag;
  logic                         parityErrorFlag;
  logic                         overrunFlag;
  logic                         breakFlag;
  logic                         carrierChangeFlag;
  logic                         ringTrailingEdgeFlag;
  logic                         dcdPrev;
  logic                         riPrev;
  logic                         loopMode;
  logic                         carrierState;
  logic                         ringIndicateState;
  logic                         clearToSendState;
  logic                         lsrRead;
  logic                         msrRead;
  logic                         pop;
  logic                         rxDataReady;
  logic                         revealNow;
  logic [ulms_pkg::ENTRY_W-1:0] headEntry;
  logic                         overrunEvt;
  logic                         fifoFlush;
  logic [2:0]                   intEvents;

  function automatic logic [7:0] charTicks(input logic parity_enable_bit);
    return parity_enable_bit ? ulms_pkg::TICKS_PAR : ulms_pkg::TICKS_NOPAR;
  endfunction

  function automatic logic parityBit(input logic [7:0] d, input logic evenSel);
    return evenSel ? ^d : ~^d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode and modem line selection

  assign lsrRead      = rdEn && (addr == ulms_pkg::LSR_ADDR);
  assign msrRead      = rdEn && (addr == ulms_pkg::MSR_ADDR);
  assign rxDataReady  = (rxCount != '0);                                // see RQ10
  assign pop          = rdEn && (addr == ulms_pkg::RBR_ADDR) && rxDataReady;
  assign fifoFlush    = wrEn && (addr == ulms_pkg::RXCTL_ADDR)
                        && (wrData[ulms_pkg::RXCTL_FIFO] != fifoMode);
  assign headEntry    = rxMem[rdPtr];
  assign revealNow    = rxDataReady && !headShown;                     // see RQ2
  assign overrunEvt   = push && (fifoMode ? (rxCount == ulms_pkg::FIFO_DEPTH)   // see RQ9
                                          : (rxDataReady && !pop));           // see RQ8
  assign loopMode     = modemControlReg[ulms_pkg::MCR_LOOP];
  assign carrierState = loopMode ? modemControlReg[ulms_pkg::MCR_AUX_OUTPUT_TWO] : !dcdInN;  // see RQ11
  assign ringIndicateState = loopMode ? modemControlReg[ulms_pkg::MCR_AUX_OUTPUT_ONE]
                                      : !ringIndicatorInN;                 // see RQ12
  assign clearToSendState  = loopMode ? modemControlReg[ulms_pkg::MCR_RTS] : !ctsInN; // see RQ13

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lineControlReg  <= ulms_pkg::REG8_RESET;
      modemControlReg <= ulms_pkg::REG8_RESET;
      fifoMode        <= 1'b0;
      baudDiv         <= ulms_pkg::DIV_RESET;
      intMask         <= ulms_pkg::INT_RESET;
    end
    else if (wrEn)
    begin
      if (addr == ulms_pkg::LCR_ADDR)
        lineControlReg <= wrData[7:0];
      else if (addr == ulms_pkg::MCR_ADDR)
        modemControlReg <= wrData[7:0];
      else if (addr == ulms_pkg::RXCTL_ADDR)
        fifoMode <= wrData[ulms_pkg::RXCTL_FIFO];
      else if (addr == ulms_pkg::DIV_ADDR)
        baudDiv <= wrData;
      else if (addr == ulms_pkg::IMASK_ADDR)
        intMask <= wrData[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oversample tick, sixteen per bit

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end
    else if (tickCnt >= baudDiv)
    begin
      tickCnt <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      tickCnt <= tickCnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // Low time of the serial input, in ticks
  always_ff @(posedge clk)
  begin
    if (!rst_b || rxIn)
      lowCnt <= '0;
    else if (tick && lowCnt != ulms_pkg::LOW_MAX)
      lowCnt <= lowCnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rxState   <= ulms_pkg::RX_IDLE;
      sampleCnt <= '0;
      bitCnt    <= '0;
      shiftData <= '0;
      parityBad <= 1'b0;
      push      <= 1'b0;
      pushEntry <= '0;
    end
    else
    begin
      push <= 1'b0;
      case (rxState)
        ulms_pkg::RX_IDLE:
        begin
          sampleCnt <= '0;
          parityBad <= 1'b0;
          if (!rxIn)
            rxState <= ulms_pkg::RX_START;
        end
        ulms_pkg::RX_START:
        begin
          if (tick)
          begin
            sampleCnt <= sampleCnt + 4'h1;
            if (sampleCnt == ulms_pkg::SAMPLE_MID)
            begin
              sampleCnt <= '0;
              bitCnt    <= '0;
              rxState   <= rxIn ? ulms_pkg::RX_IDLE : ulms_pkg::RX_DATA;
            end
          end
        end
        ulms_pkg::RX_DATA:
        begin
          if (tick)
          begin
            sampleCnt <= sampleCnt + 4'h1;
            if (sampleCnt == ulms_pkg::SAMPLE_LAST)
            begin
              shiftData <= {rxIn, shiftData[7:1]};
              bitCnt    <= bitCnt + 3'h1;
              if (bitCnt == ulms_pkg::LAST_BIT)
                rxState <= lineControlReg[ulms_pkg::LCR_PEN] ? ulms_pkg::RX_PARITY
                                                             : ulms_pkg::RX_STOP;
            end
          end
        end
        ulms_pkg::RX_PARITY:
        begin
          if (tick)
          begin
            sampleCnt <= sampleCnt + 4'h1;
            if (sampleCnt == ulms_pkg::SAMPLE_LAST)
            begin
              parityBad <= rxIn != parityBit(shiftData, lineControlReg[ulms_pkg::LCR_EPS]);
              rxState   <= ulms_pkg::RX_STOP;
            end
          end
        end
        ulms_pkg::RX_STOP:
        begin
          if (tick)
          begin
            sampleCnt <= sampleCnt + 4'h1;
            if (sampleCnt == ulms_pkg::SAMPLE_LAST)
            begin
              pushEntry <= {1'b0, !rxIn,
                            parityBad && lineControlReg[ulms_pkg::LCR_PEN], shiftData}; // see RQ1, RQ6
              if (rxIn)
              begin
                push    <= 1'b1;
                rxState <= ulms_pkg::RX_IDLE;
              end
              else if (shiftData == '0)
                rxState <= ulms_pkg::RX_CHECK;
              else
              begin
                push      <= 1'b1;
                sampleCnt <= '0;
                bitCnt    <= '0;
                parityBad <= 1'b0;
                rxState   <= ulms_pkg::RX_DATA;                         // see RQ3
              end
            end
          end
        end
        ulms_pkg::RX_CHECK:
        begin
          if (rxIn)
          begin
            push    <= 1'b1;
            rxState <= ulms_pkg::RX_IDLE;
          end
          else if (lowCnt > charTicks(lineControlReg[ulms_pkg::LCR_PEN]))  // see RQ18
          begin
            push      <= 1'b1;
            pushEntry <= {3'b111, 8'h00};                               // see RQ4, RQ5
            rxState   <= ulms_pkg::RX_WAIT_HIGH;
          end
        end
        default:
        begin
          if (rxIn)
            rxState <= ulms_pkg::RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive holding register / FIFO

  always_ff @(posedge clk)
  begin
    if (push && (fifoMode ? (rxCount != ulms_pkg::FIFO_DEPTH) : 1'b1))
      rxMem[fifoMode ? wrPtr : rdPtr] <= pushEntry;                     // see RQ8, RQ9
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || fifoFlush)
    begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      rxCount <= '0;
    end
    else if (fifoMode)
    begin
      if (push && rxCount != ulms_pkg::FIFO_DEPTH)
        wrPtr <= wrPtr + 4'h1;
      if (pop)
        rdPtr <= rdPtr + 4'h1;
      if ((push && rxCount != ulms_pkg::FIFO_DEPTH) && !pop)
        rxCount <= rxCount + 5'h01;
      else if (pop && !(push && rxCount != ulms_pkg::FIFO_DEPTH))
        rxCount <= rxCount - 5'h01;
    end
    else if (push)
      rxCount <= 5'h01;
    else if (pop)
      rxCount <= '0;                                                    // see RQ10
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || fifoFlush || pop || (push && !fifoMode))
      headShown <= 1'b0;
    else if (revealNow)
      headShown <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line status flags, set wins over read clear

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      framingErrorFlag <= 1'b0;
      parityErrorFlag  <= 1'b0;
      overrunFlag      <= 1'b0;
      breakFlag        <= 1'b0;
    end
    else
    begin
      framingErrorFlag <= (framingErrorFlag && !lsrRead)
                          || (revealNow && headEntry[ulms_pkg::ENT_FE]);  // see RQ1, RQ7
      parityErrorFlag  <= (parityErrorFlag && !lsrRead)
                          || (revealNow && headEntry[ulms_pkg::ENT_PE]);  // see RQ5, RQ7
      overrunFlag      <= (overrunFlag && !lsrRead) || overrunEvt;       // see RQ7
      breakFlag        <= (breakFlag && !lsrRead)
                          || (revealNow && headEntry[ulms_pkg::ENT_BI]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem change flags

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dcdPrev              <= 1'b0;
      riPrev               <= 1'b0;
      carrierChangeFlag    <= 1'b0;
      ringTrailingEdgeFlag <= 1'b0;
    end
    else
    begin
      dcdPrev              <= carrierState;
      riPrev               <= ringIndicateState;
      // Previous level resets inactive, so carrier held across reset flags
      carrierChangeFlag    <= (carrierChangeFlag && !msrRead)
                              || (carrierState != dcdPrev);              // see RQ14, RQ15
      ringTrailingEdgeFlag <= (ringTrailingEdgeFlag && !msrRead)
                              || (riPrev && !ringIndicateState);         // see RQ16, RQ17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and read port

  assign intEvents = {(carrierState != dcdPrev) || (riPrev && !ringIndicateState),
                      overrunEvt || (revealNow && headEntry[ulms_pkg::ENT_BI:ulms_pkg::ENT_PE] != '0),
                      push};

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      intStat <= ulms_pkg::INT_RESET;
      irq     <= 1'b0;
      rtsOutN <= 1'b1;
    end
    else
    begin
      intStat <= (intStat & ~{3{rdEn && addr == ulms_pkg::ISTAT_ADDR}}) | intEvents;
      irq     <= (intStat & intMask) != '0;
      rtsOutN <= loopMode || !modemControlReg[ulms_pkg::MCR_RTS];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || !rdEn)
      rdData <= '0;
    else if (addr == ulms_pkg::RBR_ADDR)
      rdData <= {8'h00, headEntry[7:0]};
    else if (addr == ulms_pkg::LCR_ADDR)
      rdData <= {8'h00, lineControlReg};
    else if (addr == ulms_pkg::MCR_ADDR)
      rdData <= {8'h00, modemControlReg};
    else if (addr == ulms_pkg::LSR_ADDR)
      rdData <= {11'h000, breakFlag, framingErrorFlag, parityErrorFlag,
                 overrunFlag, rxDataReady};                            // see RQ19
    else if (addr == ulms_pkg::MSR_ADDR)
      rdData <= {8'h00, carrierState, ringIndicateState, 1'b0, clearToSendState,
                 carrierChangeFlag, ringTrailingEdgeFlag, 2'b00};      // see RQ19
    else if (addr == ulms_pkg::RXCTL_ADDR)
      rdData <= {15'h0000, fifoMode};
    else if (addr == ulms_pkg::DIV_ADDR)
      rdData <= baudDiv;
    else if (addr == ulms_pkg::ISTAT_ADDR)
      rdData <= {13'h0000, intStat};
    else if (addr == ulms_pkg::IMASK_ADDR)
      rdData <= {13'h0000, intMask};
    else
      rdData <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_lsrRead;
    lsrRead && !revealNow && !overrunEvt;
  endsequence

  sequence s_msrRead;
    msrRead ##1 1'b1;
  endsequence

  property p_lsrClear;
    s_lsrRead |=> !framingErrorFlag && !parityErrorFlag && !overrunFlag;
  endproperty
  a_lsrClear: assert property (p_lsrClear) else $error("lsr read did not clear"); // see RQ7

  property p_breakFlags;
    revealNow && headEntry[ulms_pkg::ENT_BI] |=> framingErrorFlag && parityErrorFlag && breakFlag;
  endproperty
  a_breakFlags: assert property (p_breakFlags) else $error("break flags missing"); // see RQ4

  property p_peCause;
    $rose(parityErrorFlag) |-> $past(revealNow && headEntry[ulms_pkg::ENT_PE]);
  endproperty
  a_peCause: assert property (p_peCause) else $error("parity flag without cause"); // see RQ5

  property p_peGated;
    push && !lineControlReg[ulms_pkg::LCR_PEN] && !pushEntry[ulms_pkg::ENT_BI]
      |-> !pushEntry[ulms_pkg::ENT_PE];
  endproperty
  a_peGated: assert property (p_peGated) else $error("parity error while disabled"); // see RQ6

  property p_overrunFifo;
    push && fifoMode && rxCount == ulms_pkg::FIFO_DEPTH && !pop && !fifoFlush
      |=> overrunFlag && rxCount == ulms_pkg::FIFO_DEPTH;
  endproperty
  a_overrunFifo: assert property (p_overrunFifo) else $error("fifo overrun wrong"); // see RQ9

  property p_overrunHold;
    push && !fifoMode && rxDataReady && !pop && !fifoFlush
      |=> overrunFlag && headEntry[7:0] == $past(pushEntry[7:0]);
  endproperty
  a_overrunHold: assert property (p_overrunHold) else $error("holding overrun wrong"); // see RQ8

  property p_resync;
    rxState == ulms_pkg::RX_STOP && tick && sampleCnt == ulms_pkg::SAMPLE_LAST
      && !rxIn && shiftData != '0 |=> rxState == ulms_pkg::RX_DATA && push;
  endproperty
  a_resync: assert property (p_resync) else $error("no resync after framing error"); // see RQ3

  property p_carrierBit;
    s_msrRead |-> rdData[ulms_pkg::MSR_DCD] == $past(carrierState)
                  && rdData[ulms_pkg::MSR_RI] == $past(ringIndicateState);
  endproperty
  a_carrierBit: assert property (p_carrierBit) else $error("modem state bit wrong"); // see RQ11

  property p_carrierChange;
    carrierState != dcdPrev |=> carrierChangeFlag;
  endproperty
  a_carrierChange: assert property (p_carrierChange) else $error("carrier change lost"); // see RQ14

  property p_ringEdge;
    riPrev && !ringIndicateState |=> ringTrailingEdgeFlag;
  endproperty
  a_ringEdge: assert property (p_ringEdge) else $error("ring trailing edge lost"); // see RQ16

  property p_reserved;
    rdEn ##1 1'b1 |-> rdData[15:8] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // see RQ19

endmodule // ulms_status

// file: tb/uart_line_modem_status_test.sv
`timescale 1ns/10ps
module uart_line_modem_status_test;
  localparam logic [31:0] LINE_STATUS_REG = ulms_pkg::LSR_ADDR;
  localparam logic [31:0] MODEM_STATUS_REG = ulms_pkg::MSR_ADDR;
  localparam logic [31:0] RX_BUFFER_REG = ulms_pkg::RBR_ADDR;
  logic        clk;
  logic        rst_b;
  logic [31:0] addr;
  logic [15:0] wrData;
  logic [15:0] rdData;
  logic        wrEn;
  logic        rdEn;
  logic        irq;
  logic        rtsOutN;
  logic        rxIn;
  logic        dcdInN;
  logic        ringIndicatorInN;
  logic        ctsInN;
  int          errTotal;
  int          checkCount;

  ulms_status dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .rxIn(rxIn), .dcdInN(dcdInN),
    .ringIndicatorInN(ringIndicatorInN), .ctsInN(ctsInN), .irq(irq), .rtsOutN(rtsOutN));
  ulms_modem_model model_u (.clk(clk), .rxIn(rxIn), .dcdInN(dcdInN),
    .ringIndicatorInN(ringIndicatorInN), .ctsInN(ctsInN));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errTotal, checkCount);
    if (errTotal == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(LINE_STATUS_REG, 16'h0000);
    rd(MODEM_STATUS_REG, 16'h0000);
    wr(LINE_STATUS_REG, 16'hFFFF);
    rd(LINE_STATUS_REG, 16'h0000);
    rd(32'h5000_11F0, 16'h0000);
  endtask
  task automatic t_rx_irq();
    wr(ulms_pkg::IMASK_ADDR, 16'h0001);
    model_u.frame(8'h3C, 1'b0, 1'b0, 1'b1);
    nap(3);
    chk({15'h0000, irq}, 16'h0001);
    rd(LINE_STATUS_REG, 16'h0001);
    rd(ulms_pkg::ISTAT_ADDR, 16'h0001);
    rd(RX_BUFFER_REG, 16'h003C);
    rd(LINE_STATUS_REG, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(ulms_pkg::IMASK_ADDR, 16'h0000);
  endtask
  task automatic t_frame_err();
    model_u.frame(8'h5A, 1'b0, 1'b0, 1'b0);
    model_u.line(1'b1, 11);
    rd(LINE_STATUS_REG, 16'h000B);
    chk({15'h0000, irq}, 16'h0000);
    rd(LINE_STATUS_REG, 16'h0001);
    rd(RX_BUFFER_REG, 16'h00FF);
  endtask
  task automatic t_par_break();
    wr(ulms_pkg::LCR_ADDR, 16'h0018);
    model_u.frame(8'h07, 1'b1, 1'b0, 1'b1);
    rd(LINE_STATUS_REG, 16'h0005);
    rd(RX_BUFFER_REG, 16'h0007);
    model_u.line(1'b0, 13);
    model_u.line(1'b1, 2);
    rd(LINE_STATUS_REG, 16'h001D);
    rd(RX_BUFFER_REG, 16'h0000);
  endtask
  task automatic t_fifo();
    wr(ulms_pkg::RXCTL_ADDR, 16'h0001);
    model_u.frame(8'h11, 1'b1, ^8'h11, 1'b1);
    model_u.frame(8'h22, 1'b1, ~^8'h22, 1'b1);
    for (int i = 0; i < 15; i++) model_u.frame(8'h40 + i[7:0], 1'b1, ^(8'h40 + i[7:0]), 1'b1);
    rd(LINE_STATUS_REG, 16'h0003);
    rd(RX_BUFFER_REG, 16'h0011);
    rd(LINE_STATUS_REG, 16'h0005);
    rd(RX_BUFFER_REG, 16'h0022);
    for (int i = 0; i < 14; i++) rd(RX_BUFFER_REG, 16'h0040 + i[15:0]);
    rd(LINE_STATUS_REG, 16'h0000);
    wr(ulms_pkg::RXCTL_ADDR, 16'h0000);
    wr(ulms_pkg::LCR_ADDR, 16'h0000);
  endtask
  task automatic t_modem();
    model_u.lines(1'b0, 1'b1, 1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(MODEM_STATUS_REG, 16'h0088);
    rd(MODEM_STATUS_REG, 16'h0080);
    model_u.lines(1'b1, 1'b0, 1'b0);
    rd(MODEM_STATUS_REG, 16'h0058);
    model_u.lines(1'b1, 1'b1, 1'b1);
    rd(MODEM_STATUS_REG, 16'h0004);
    wr(ulms_pkg::MCR_ADDR, 16'h0002);
    nap(2);
    chk({15'h0000, rtsOutN}, 16'h0000);
    wr(ulms_pkg::MCR_ADDR, 16'h001E);
    rd(MODEM_STATUS_REG, 16'h00D8);
    chk({15'h0000, rtsOutN}, 16'h0001);
    wr(ulms_pkg::MCR_ADDR, 16'h001A);
    rd(MODEM_STATUS_REG, 16'h0094);
    wr(ulms_pkg::MCR_ADDR, 16'h0012);
    rd(MODEM_STATUS_REG, 16'h0018);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    errTotal = 0;
    checkCount = 0;
    rst_b = 1'b0;
    addr = 32'h0000_0000;
    wrData = 16'h0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_rx_irq();
    t_frame_err();
    t_par_break();
    t_fifo();
    t_modem();
    end_sim();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #300000;
    errTotal++;
    end_sim();
  end
endmodule // uart_line_modem_status_test

// file: tb/ulms_modem_model.sv
`timescale 1ns/10ps
module ulms_modem_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk,
  output      logic rxIn,
  output      logic dcdInN,
  output      logic ringIndicatorInN,
  output      logic ctsInN
);
  initial
  begin
    rxIn = 1'b1;
    dcdInN = 1'b1;
    ringIndicatorInN = 1'b1;
    ctsInN = 1'b1;
  end
  // Hold the serial line for whole bit times
  task automatic line(input logic lvl, input int nBits);
    @(posedge clk);
    rxIn <= lvl;
    repeat (nBits * BIT_CLKS - 1) @(posedge clk);
  endtask
  // Start, data LSB first, optional parity, stop
  task automatic frame(input logic [7:0] d, input logic usePar, input logic par,
                       input logic stopLvl);
    line(1'b0, 1);
    for (int i = 0; i < 8; i++) line(d[i], 1);
    if (usePar) line(par, 1);
    line(stopLvl, 1);
  endtask
  task automatic lines(input logic dcd, input logic ri, input logic cts);
    @(posedge clk);
    dcdInN <= dcd;
    ringIndicatorInN <= ri;
    ctsInN <= cts;
  endtask
endmodule // ulms_modem_model
